// File: core/gpio_cfg.svh
// Register offsets, reset values and the summary of port behaviour
// Summary of operation
// - Every reset clears all direction bits, so pins start as inputs.
// - Reset sets slew limit, clears drive strength and clears pullup enable.
// - After reset all shared peripheral and analog functions are disabled.
// - An enabled shared peripheral takes the pin from the port logic.
// - Direction zero: driver off, data read returns the synchronised pin level.
// - Direction one: driver on, data read returns the latched data.
// - Direction bit picks the read source even under peripheral control.
// - Analog function disables digital use; data read returns zero.
// - Analog function beats an alternate digital function on one pin.
// - Pullup on only when enabled and nothing drives the pin.
// - Pullup forced off while analog controls the pin.
// - Slew limit applies to outputs only; no effect on inputs.
// - Drive strength bit selects high drive, clear gives low drive.
// - Pin control registers are independent of data and direction.
// - Data writes latch all bits; only outputs show them on pins.
`ifndef GPIO_CFG_SVH
`define GPIO_CFG_SVH
`define OFS_DATA 3'h0
`define OFS_DIR 3'h1
`define OFS_PULL 3'h2
`define OFS_SLEW 3'h3
`define OFS_DRIVE 3'h4
`define OFS_ALT_EN 3'h5
`define OFS_ANA_EN 3'h6
`define RST_DATA 1'b0
`define RST_DIR 1'b0
`define RST_PULL 1'b0
`define RST_SLEW 1'b1
`define RST_DRIVE 1'b0
`define RST_FUNC_EN 1'b0
`endif

// File: core/gpio_pkg.sv
// Types shared by the port files
package gpio_pkg;
    typedef enum logic [1:0] {
        OWNER_PORT,
        OWNER_PERIPH,
        OWNER_ANALOG
    } pin_owner_e;
endpackage

// File: core/pin_sync.sv
// Two-stage synchroniser for a group of pin levels
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    // First stage read only by the second
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

// File: core/pin_owner_mux.sv
// Per-pin ownership and pad control selection
`timescale 1ns/1ps
module pin_owner_mux (
    // Port logic settings
    input wire logic port_dir,
    input wire logic port_data,
    input wire logic pull_en,
    input wire logic slew_en,
    input wire logic drive_en,
    // Shared functions
    input wire logic alt_en,
    input wire logic alt_oe,
    input wire logic alt_out,
    input wire logic ana_en,
    // Pad controls
    output gpio_pkg::pin_owner_e owner,
    output logic pad_out,
    output logic pad_oe_n,
    output logic pad_pull,
    output logic pad_slew,
    output logic pad_drive
);
    logic drive_now;

    // Analog first, then peripheral, then port
    always_comb begin
        if (ana_en) begin
            owner = gpio_pkg::OWNER_ANALOG;
        end else if (alt_en) begin
            owner = gpio_pkg::OWNER_PERIPH;
        end else begin
            owner = gpio_pkg::OWNER_PORT;
        end
    end

    // Driver and pad settings by owner
    always_comb begin
        drive_now = 1'b0;
        pad_out = 1'b0;
        unique case (owner)
            gpio_pkg::OWNER_PORT: begin
                drive_now = port_dir;
                pad_out = port_data;
            end
            gpio_pkg::OWNER_PERIPH: begin
                drive_now = alt_oe;
                pad_out = alt_out;
            end
            gpio_pkg::OWNER_ANALOG: begin
                drive_now = 1'b0;
                pad_out = 1'b0;
            end
            default: begin
                drive_now = 1'b0;
                pad_out = 1'b0;
            end
        endcase
        pad_oe_n = ~drive_now;
        pad_pull = pull_en & ~drive_now & (owner != gpio_pkg::OWNER_ANALOG);
        pad_slew = slew_en & drive_now;
        pad_drive = drive_en & drive_now;
    end
endmodule

// File: core/gpio_port.sv
// Parallel I/O port with per-pin pullup, slew and drive control
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "gpio_cfg.svh"
module gpio_port #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Register port
    input wire logic [2:0] reg_addr,
    input wire logic [WIDTH-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [WIDTH-1:0] reg_rdata,
    // Shared peripheral functions
    input wire logic [WIDTH-1:0] alt_oe,
    input wire logic [WIDTH-1:0] alt_out,
    // Pins
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_out,
    output logic [WIDTH-1:0] pin_oe_n,
    output logic [WIDTH-1:0] pin_pull,
    output logic [WIDTH-1:0] pin_slew,
    output logic [WIDTH-1:0] pin_drive
);
    logic [WIDTH-1:0] data_q;
    logic [WIDTH-1:0] dir_q;
    logic [WIDTH-1:0] pull_q;
    logic [WIDTH-1:0] slew_q;
    logic [WIDTH-1:0] drive_q;
    logic [WIDTH-1:0] alt_en_q;
    logic [WIDTH-1:0] ana_en_q;
    logic [WIDTH-1:0] pin_sync_lvl;
    logic [WIDTH-1:0] out_d;
    logic [WIDTH-1:0] oe_n_d;
    logic [WIDTH-1:0] pull_d;
    logic [WIDTH-1:0] slew_d;
    logic [WIDTH-1:0] drive_d;
    logic [WIDTH-1:0] rdata_d;
    gpio_pkg::pin_owner_e owner_d [WIDTH];

    // Write strobe decode
    function automatic logic wr_hit(input logic [2:0] ofs);
        return reg_wr && (reg_addr == ofs);
    endfunction

    // Pin inputs through the synchroniser
    pin_sync #(.WIDTH(WIDTH)) u_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .async_in(pin_in),
        .sync_out(pin_sync_lvl)
    );

    // Data latch takes all bits on every write
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            data_q <= {WIDTH{`RST_DATA}};
        end else if (wr_hit(`OFS_DATA)) begin
            data_q <= reg_wdata;
        end
    end

    // Direction bits
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dir_q <= {WIDTH{`RST_DIR}};
        end else if (wr_hit(`OFS_DIR)) begin
            dir_q <= reg_wdata;
        end
    end

    // Pin control bits, separate from data and direction
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pull_q <= {WIDTH{`RST_PULL}};
            slew_q <= {WIDTH{`RST_SLEW}};
            drive_q <= {WIDTH{`RST_DRIVE}};
        end else begin
            if (wr_hit(`OFS_PULL)) begin
                pull_q <= reg_wdata;
            end
            if (wr_hit(`OFS_SLEW)) begin
                slew_q <= reg_wdata;
            end
            if (wr_hit(`OFS_DRIVE)) begin
                drive_q <= reg_wdata;
            end
        end
    end

    // Shared function enables, off after reset
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            alt_en_q <= {WIDTH{`RST_FUNC_EN}};
            ana_en_q <= {WIDTH{`RST_FUNC_EN}};
        end else begin
            if (wr_hit(`OFS_ALT_EN)) begin
                alt_en_q <= reg_wdata;
            end
            if (wr_hit(`OFS_ANA_EN)) begin
                ana_en_q <= reg_wdata;
            end
        end
    end

    // Per-pin ownership
    for (genvar i = 0; i < WIDTH; i++) begin : g_pin
        pin_owner_mux u_mux (
            .port_dir(dir_q[i]),
            .port_data(data_q[i]),
            .pull_en(pull_q[i]),
            .slew_en(slew_q[i]),
            .drive_en(drive_q[i]),
            .alt_en(alt_en_q[i]),
            .alt_oe(alt_oe[i]),
            .alt_out(alt_out[i]),
            .ana_en(ana_en_q[i]),
            .owner(owner_d[i]),
            .pad_out(out_d[i]),
            .pad_oe_n(oe_n_d[i]),
            .pad_pull(pull_d[i]),
            .pad_slew(slew_d[i]),
            .pad_drive(drive_d[i])
        );
    end

    // Pad outputs registered
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_out <= '0;
            pin_oe_n <= '1;
            pin_pull <= '0;
            pin_slew <= '0;
            pin_drive <= '0;
        end else begin
            pin_out <= out_d;
            pin_oe_n <= oe_n_d;
            pin_pull <= pull_d;
            pin_slew <= slew_d;
            pin_drive <= drive_d;
        end
    end

    // Read data selection
    always_comb begin
        rdata_d = '0;
        unique case (reg_addr)
            `OFS_DATA: rdata_d = ((dir_q & data_q) | (~dir_q & pin_sync_lvl)) & ~ana_en_q;
            `OFS_DIR: rdata_d = dir_q;
            `OFS_PULL: rdata_d = pull_q;
            `OFS_SLEW: rdata_d = slew_q;
            `OFS_DRIVE: rdata_d = drive_q;
            `OFS_ALT_EN: rdata_d = alt_en_q;
            `OFS_ANA_EN: rdata_d = ana_en_q;
            default: rdata_d = '0;
        endcase
    end

    // Read data stands the cycle after the strobe only
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            reg_rdata <= rdata_d;
        end else begin
            reg_rdata <= '0;
        end
    end

    // Output pin shows latched data one cycle on
    output_data_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (dir_q[0] && !alt_en_q[0] && !ana_en_q[0]) |=> (pin_out[0] == $past(data_q[0])))
        else $error("output pin not driven from data latch");

    // Input pin never driven
    input_off_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (!dir_q[0] && !alt_en_q[0]) |=> pin_oe_n[0])
        else $error("input pin driven");

    // Analog forces pullup and driver off
    analog_off_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ana_en_q[2] |=> (pin_oe_n[2] && !pin_pull[2]))
        else $error("analog pin not released");

    // Analog read gives zero
    analog_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (reg_rd && reg_addr == `OFS_DATA && ana_en_q[2]) |=> !reg_rdata[2])
        else $error("analog bit read nonzero");

    // Peripheral controls enable
    periph_own_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (alt_en_q[2] && !ana_en_q[2]) |=> (pin_oe_n[2] == !$past(alt_oe[2])))
        else $error("peripheral lost pin");

    // Pullup off while driven
    pull_drive_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !pin_oe_n[0] |-> !pin_pull[0])
        else $error("pullup on driven pin");

    // Slew ignored on input
    slew_input_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        pin_oe_n[3] |-> !pin_slew[3])
        else $error("slew on input");

    // Drive select follows bit
    drive_sel_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (dir_q[0] && drive_q[0] && !alt_en_q[0] && !ana_en_q[0]) |=> pin_drive[0])
        else $error("high drive not selected");

    // Data write leaves slew and direction bits alone
    ctrl_indep_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (reg_wr && reg_addr == `OFS_DATA) |=> $stable(slew_q) && $stable(dir_q))
        else $error("data write disturbed control");
endmodule

// File: testbench/pin_partner.sv
// Model of the external pins: port drivers, outside sources and pullups
`timescale 1ns/1ps
module pin_partner (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Pad side of the port
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe_n,
    input wire logic [7:0] pin_pull,
    // Outside world
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_lvl,
    output logic [7:0] pin_in
);
    logic [7:0] float_q;
    // Undriven, unpulled pins wander every cycle
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            float_q <= 8'h5a;
        end else begin
            float_q <= ~float_q;
        end
    end
    // Port driver first, then outside source, then pullup or a floating level
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!pin_oe_n[i]) begin
                pin_in[i] = pin_out[i];
            end else if (ext_en[i]) begin
                pin_in[i] = ext_lvl[i];
            end else begin
                pin_in[i] = pin_pull[i] | float_q[i];
            end
        end
    end
endmodule

// File: testbench/test_gpio_port.sv
// Self-checking bench for the parallel I/O port
`timescale 1ns/1ps
module test_gpio_port;
    typedef struct packed {
        logic [7:0] dir, dat, pul, slw, drv, alt, ana, aoe, aout, ext;
        logic [7:0] oen, pu, sl, dr, po, rd;
    } row_s;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] alt_oe = 8'h00, alt_out = 8'h00, ext_lvl = 8'h00, ext_en = 8'hff;
    logic [7:0] reg_rdata, pin_in, pin_out, pin_oe_n, pin_pull, pin_slew, pin_drive, rdv;
    int n_mismatch = 0;
    int cmp_count = 0;
    row_s rows [3];
    // Free-running bus clock
    always #4 sys_clk = ~sys_clk;
    gpio_port #(.WIDTH(8)) gpio_port_inst (.sys_clk(sys_clk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .alt_oe(alt_oe), .alt_out(alt_out), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pull(pin_pull), .pin_slew(pin_slew),
        .pin_drive(pin_drive));
    pin_partner pin_partner_inst (.sys_clk(sys_clk), .rst_n(rst_n), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .pin_pull(pin_pull), .ext_en(ext_en), .ext_lvl(ext_lvl),
        .pin_in(pin_in));
    // Compare one byte and count it
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    // One-cycle register write
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    // One-cycle register read, data taken in the following cycle
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // Reset, then pad states, register defaults and the unmapped offset
    task automatic do_reset();
        logic [7:0] rv [7] = '{8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00};
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        chk("oe_n", 8'hff, pin_oe_n);
        chk("slew", 8'h00, pin_slew);
        for (int a = 1; a < 7; a++) begin
            rd(a[2:0], rdv);
            chk("reg", rv[a], rdv);
        end
        chk("oe_n", 8'hff, pin_oe_n);
        wr(3'h7, 8'hff);
        rd(3'h7, rdv);
        chk("unmapped", 8'h00, rdv);
        rd(3'h1, rdv);
        chk("dir", 8'h00, rdv);
    endtask
    // Verdict and end of run
    task automatic conclude();
        $display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Table of settings, then a second reset and the transitions
    initial begin
        logic [7:0] v [7];
        rows = '{'{8'hf0, 8'ha5, 8'hff, 8'h3c, 8'hc3, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0f,
                   8'h0f, 8'h0f, 8'h30, 8'hc0, 8'ha0, 8'haf},
                 '{8'h0f, 8'h55, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00, 8'h33, 8'h21, 8'h00,
                   8'hcc, 8'hcc, 8'h33, 8'h33, 8'h21, 8'h25},
                 '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hf0, 8'h3c, 8'hff, 8'h00, 8'haa,
                   8'h3c, 8'h00, 8'hc3, 8'hc3, 8'h03, 8'hc3}};
        do_reset();
        foreach (rows[r]) begin
            @(posedge sys_clk);
            alt_oe <= rows[r].aoe;
            alt_out <= rows[r].aout;
            ext_lvl <= rows[r].ext;
            v = '{rows[r].dat, rows[r].dir, rows[r].pul, rows[r].slw, rows[r].drv,
                  rows[r].alt, rows[r].ana};
            for (int a = 0; a < 7; a++) begin
                wr(a[2:0], v[a]);
            end
            repeat (6) @(posedge sys_clk);
            #1;
            chk("oe_n", rows[r].oen, pin_oe_n);
            chk("pull", rows[r].pu, pin_pull);
            chk("slew", rows[r].sl, pin_slew);
            chk("drive", rows[r].dr, pin_drive);
            chk("pin_out", rows[r].po, pin_out & ~pin_oe_n);
            rd(3'h0, rdv);
            chk("data", rows[r].rd, rdv);
        end
        do_reset();
        @(posedge sys_clk);
        ext_en <= 8'h00;
        wr(3'h2, 8'hff);
        repeat (4) @(posedge sys_clk);
        #1;
        chk("pull", 8'hff, pin_pull);
        rd(3'h0, rdv);
        chk("data", 8'hff, rdv);
        wr(3'h0, 8'h5a);
        #1;
        chk("oe_n", 8'hff, pin_oe_n);
        wr(3'h1, 8'hff);
        @(posedge sys_clk);
        #1;
        chk("oe_n", 8'h00, pin_oe_n);
        chk("pin_out", 8'h5a, pin_out);
        chk("pull", 8'h00, pin_pull);
        rd(3'h1, rdv);
        chk("dir", 8'hff, rdv);
        rd(3'h2, rdv);
        chk("pullreg", 8'hff, rdv);
        conclude();
    end
endmodule
